// *** rtl/dccr_channel.v ***
// One comparator channel: output conditioning, synchroniser and edge flags.
`include "dccr_map.vh"

module dccr_channel
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Analog side
  input  wire       raw_i,
  input  wire       on_i,
  // Flag clears from software
  input  wire       clr_rise_i,
  input  wire       clr_fall_i,
  // State
  output wire       result_o,
  output reg        rise_flag_o,
  output reg        fall_flag_o
);

  reg  gated_q;
  reg  sync_q;
  reg  prev_q;
  wire rise_ev;
  wire fall_ev;

  // ==========================================================================
  // Synchroniser
  // The gate is registered first so the raw output is never sampled twice.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      gated_q <= 1'b0;
      sync_q  <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      gated_q <= raw_i & on_i;
      sync_q  <= gated_q;
      prev_q  <= sync_q;
    end
  end

  assign result_o = sync_q;
  assign rise_ev  = sync_q & ~prev_q;
  assign fall_ev  = ~sync_q & prev_q;

  // ==========================================================================
  // Sticky edge flags
  // Flags fire regardless of interrupt enables; a set beats a clear.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rise_flag_o <= 1'b0;
      fall_flag_o <= 1'b0;
    end
    else
    begin
      if (rise_ev)
        rise_flag_o <= 1'b1;
      else if (clr_rise_i)
        rise_flag_o <= 1'b0;
      if (fall_ev)
        fall_flag_o <= 1'b1;
      else if (clr_fall_i)
        fall_flag_o <= 1'b0;
    end
  end

endmodule

// *** rtl/dccr_map.vh ***
// Register addresses, field positions and reset values of the comparator bank.
`ifndef DCCR_MAP_VH
`define DCCR_MAP_VH
// ==========================================================================
// Special-function-register addresses
`define DCCR_ADDR_B_CTRL    8'h9A
`define DCCR_ADDR_A_CTRL    8'h9B
`define DCCR_ADDR_A_MODE    8'h9D
// ==========================================================================
// Control register fields
`define DCCR_CTL_ON         7
`define DCCR_CTL_RESULT     6
`define DCCR_CTL_RISE       5
`define DCCR_CTL_FALL       4
`define DCCR_CTL_PHYS_HI    3
`define DCCR_CTL_PHYS_LO    2
`define DCCR_CTL_NHYS_HI    1
`define DCCR_CTL_NHYS_LO    0
`define DCCR_CTL_RESET      8'h00
// ==========================================================================
// Mode register fields
`define DCCR_MD_FIXED       7
`define DCCR_MD_RISE_EN     5
`define DCCR_MD_FALL_EN     4
`define DCCR_MD_SPD_HI      1
`define DCCR_MD_SPD_LO      0
`define DCCR_MD_SPD_RESET   2'h2
`define DCCR_FIELD_RESET    2'h0
`endif

// *** rtl/dccr_regs.v ***
// Control and status registers for two voltage comparators.
// Notes on behaviour
// - Comparator idle until on bit set.
// - Clearing on bit powers comparator down.
// - Spurious flags may appear after setting changes.
// - Bit 6 reads synchronised comparator result.
// - Bit 5 sticky rise flag, software clears.
// - Bit 4 sticky fall flag, software clears.
// - Bits 3-2 select positive hysteresis.
// - Bits 1-0 select negative hysteresis.
// - Mode bit 5 enables rise interrupt.
// - Mode bit 4 enables fall interrupt.
// - Mode bits 1:0 response time, reset 10.
// - Mode bit 7 reads one; 6,3:2 zero.
// - Second control register mirrors the first.
// - Disabled comparator feeds logic zero.
// - Comparator output synchronised to system clock.
// - Flags set regardless of interrupt enables.
// - Interrupt needs flag, enable, source, global.
`include "dccr_map.vh"

module dccr_regs
(
  // Clock and reset
  input  wire       REF_CLK_I,
  input  wire       RST_N_I,
  // Special-function-register access
  input  wire [7:0] SFR_ADDR_I,
  input  wire       SFR_WR_I,
  input  wire       SFR_RD_I,
  input  wire [7:0] SFR_WDATA_I,
  output reg  [7:0] SFR_RDATA_O,
  output wire       SFR_HIT_O,
  // Analog comparators
  input  wire       CMP_A_RAW_I,
  input  wire       CMP_B_RAW_I,
  output wire       CMP_A_ON_O,
  output wire       CMP_B_ON_O,
  output wire [1:0] CMP_A_POS_HYST_O,
  output wire [1:0] CMP_A_NEG_HYST_O,
  output wire [1:0] CMP_B_POS_HYST_O,
  output wire [1:0] CMP_B_NEG_HYST_O,
  output wire [1:0] CMP_A_SPEED_SEL_O,
  // Interrupt controller
  input  wire       CMP_A_SRC_EN_I,
  input  wire       GLOBAL_IRQ_EN_I,
  output wire       CMP_A_IRQ_O
);

  reg        cmp_a_on_bit_q;
  reg        cmp_b_on_bit_q;
  reg  [1:0] cmp_a_pos_hyst_q;
  reg  [1:0] cmp_a_neg_hyst_q;
  reg  [1:0] cmp_b_pos_hyst_q;
  reg  [1:0] cmp_b_neg_hyst_q;
  reg        cmp_a_rise_irq_en_q;
  reg        cmp_a_fall_irq_en_q;
  reg  [1:0] cmp_a_speed_sel_q;
  wire       cmp_a_result_bit;
  wire       cmp_b_result_bit;
  wire       cmp_a_rise_flag;
  wire       cmp_a_fall_flag;
  wire       cmp_b_rise_flag;
  wire       cmp_b_fall_flag;
  wire       wr_a_ctl;
  wire       wr_b_ctl;
  wire       wr_a_md;
  wire       clr_a_rise;
  wire       clr_a_fall;
  wire       clr_b_rise;
  wire       clr_b_fall;

  // ==========================================================================
  // Address decode
  function sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  assign wr_a_ctl  = SFR_WR_I & sel(SFR_ADDR_I, `DCCR_ADDR_A_CTRL);
  assign wr_b_ctl  = SFR_WR_I & sel(SFR_ADDR_I, `DCCR_ADDR_B_CTRL);
  assign wr_a_md   = SFR_WR_I & sel(SFR_ADDR_I, `DCCR_ADDR_A_MODE);
  assign SFR_HIT_O = sel(SFR_ADDR_I, `DCCR_ADDR_A_CTRL)
                   | sel(SFR_ADDR_I, `DCCR_ADDR_B_CTRL)
                   | sel(SFR_ADDR_I, `DCCR_ADDR_A_MODE);

  // Writing a one to a flag leaves it alone; only a zero clears it.
  assign clr_a_rise = wr_a_ctl & ~SFR_WDATA_I[`DCCR_CTL_RISE];
  assign clr_a_fall = wr_a_ctl & ~SFR_WDATA_I[`DCCR_CTL_FALL];
  assign clr_b_rise = wr_b_ctl & ~SFR_WDATA_I[`DCCR_CTL_RISE];
  assign clr_b_fall = wr_b_ctl & ~SFR_WDATA_I[`DCCR_CTL_FALL];

  // ==========================================================================
  // Writable fields
  always @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      cmp_a_on_bit_q      <= 1'b0;
      cmp_b_on_bit_q      <= 1'b0;
      cmp_a_pos_hyst_q    <= `DCCR_FIELD_RESET;
      cmp_a_neg_hyst_q    <= `DCCR_FIELD_RESET;
      cmp_b_pos_hyst_q    <= `DCCR_FIELD_RESET;
      cmp_b_neg_hyst_q    <= `DCCR_FIELD_RESET;
      cmp_a_rise_irq_en_q <= 1'b0;
      cmp_a_fall_irq_en_q <= 1'b0;
      cmp_a_speed_sel_q   <= `DCCR_MD_SPD_RESET;
    end
    else
    begin
      if (wr_a_ctl)
      begin
        cmp_a_on_bit_q   <= SFR_WDATA_I[`DCCR_CTL_ON];
        cmp_a_pos_hyst_q <= SFR_WDATA_I[`DCCR_CTL_PHYS_HI:`DCCR_CTL_PHYS_LO];
        cmp_a_neg_hyst_q <= SFR_WDATA_I[`DCCR_CTL_NHYS_HI:`DCCR_CTL_NHYS_LO];
      end
      if (wr_b_ctl)
      begin
        cmp_b_on_bit_q   <= SFR_WDATA_I[`DCCR_CTL_ON];
        cmp_b_pos_hyst_q <= SFR_WDATA_I[`DCCR_CTL_PHYS_HI:`DCCR_CTL_PHYS_LO];
        cmp_b_neg_hyst_q <= SFR_WDATA_I[`DCCR_CTL_NHYS_HI:`DCCR_CTL_NHYS_LO];
      end
      if (wr_a_md)
      begin
        cmp_a_rise_irq_en_q <= SFR_WDATA_I[`DCCR_MD_RISE_EN];
        cmp_a_fall_irq_en_q <= SFR_WDATA_I[`DCCR_MD_FALL_EN];
        cmp_a_speed_sel_q   <= SFR_WDATA_I[`DCCR_MD_SPD_HI:`DCCR_MD_SPD_LO];
      end
    end
  end

  // ==========================================================================
  // Analog controls
  // Settings changes may glitch the comparator and set false flags; the
  // block does not mask them, software must clear the flags afterwards.
  assign CMP_A_ON_O        = cmp_a_on_bit_q;
  assign CMP_B_ON_O        = cmp_b_on_bit_q;
  assign CMP_A_POS_HYST_O  = cmp_a_pos_hyst_q;
  assign CMP_A_NEG_HYST_O  = cmp_a_neg_hyst_q;
  assign CMP_B_POS_HYST_O  = cmp_b_pos_hyst_q;
  assign CMP_B_NEG_HYST_O  = cmp_b_neg_hyst_q;
  assign CMP_A_SPEED_SEL_O = cmp_a_speed_sel_q;

  // ==========================================================================
  // Channels
  dccr_channel u_chan_a
  (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RST_N_I),
    .raw_i       (CMP_A_RAW_I),
    .on_i        (cmp_a_on_bit_q),
    .clr_rise_i  (clr_a_rise),
    .clr_fall_i  (clr_a_fall),
    .result_o    (cmp_a_result_bit),
    .rise_flag_o (cmp_a_rise_flag),
    .fall_flag_o (cmp_a_fall_flag)
  );

  dccr_channel u_chan_b
  (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RST_N_I),
    .raw_i       (CMP_B_RAW_I),
    .on_i        (cmp_b_on_bit_q),
    .clr_rise_i  (clr_b_rise),
    .clr_fall_i  (clr_b_fall),
    .result_o    (cmp_b_result_bit),
    .rise_flag_o (cmp_b_rise_flag),
    .fall_flag_o (cmp_b_fall_flag)
  );

  // ==========================================================================
  // Interrupt request
  assign CMP_A_IRQ_O = ((cmp_a_rise_flag & cmp_a_rise_irq_en_q)
                     | (cmp_a_fall_flag & cmp_a_fall_irq_en_q))
                     & CMP_A_SRC_EN_I & GLOBAL_IRQ_EN_I;

  // ==========================================================================
  // Read data
  // Unmapped addresses return zero so another peripheral can share the bus.
  always @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
      SFR_RDATA_O <= 8'h00;
    else if (SFR_RD_I)
    begin
      case (SFR_ADDR_I)
        `DCCR_ADDR_A_CTRL:
          SFR_RDATA_O <= {cmp_a_on_bit_q, cmp_a_result_bit,
                          cmp_a_rise_flag, cmp_a_fall_flag,
                          cmp_a_pos_hyst_q, cmp_a_neg_hyst_q};
        `DCCR_ADDR_B_CTRL:
          SFR_RDATA_O <= {cmp_b_on_bit_q, cmp_b_result_bit,
                          cmp_b_rise_flag, cmp_b_fall_flag,
                          cmp_b_pos_hyst_q, cmp_b_neg_hyst_q};
        `DCCR_ADDR_A_MODE:
          SFR_RDATA_O <= {1'b1, 1'b0, cmp_a_rise_irq_en_q,
                          cmp_a_fall_irq_en_q, 2'b00, cmp_a_speed_sel_q};
        default:
          SFR_RDATA_O <= 8'h00;
      endcase
    end
  end

endmodule

// *** verif/dccr_regs_properties.sv ***
// Bound checker for the comparator register bank.
module dccr_regs_properties
(
  // Clock and reset
  input wire       REF_CLK_I,
  input wire       RST_N_I,
  // Register access
  input wire [7:0] SFR_ADDR_I,
  input wire       SFR_WR_I,
  input wire       SFR_RD_I,
  input wire [7:0] SFR_WDATA_I,
  input wire [7:0] SFR_RDATA_O,
  input wire       SFR_HIT_O,
  // Comparator side
  input wire       CMP_A_ON_O,
  input wire [1:0] CMP_A_POS_HYST_O,
  input wire [1:0] CMP_A_NEG_HYST_O,
  input wire [1:0] CMP_A_SPEED_SEL_O,
  input wire       CMP_A_SRC_EN_I,
  input wire       GLOBAL_IRQ_EN_I,
  input wire       CMP_A_IRQ_O
);
  wire wa = SFR_WR_I && SFR_ADDR_I == 8'h9B;
  wire wm = SFR_WR_I && SFR_ADDR_I == 8'h9D;
  wire ra = SFR_RD_I && SFR_ADDR_I == 8'h9B;
  wire rm = SFR_RD_I && SFR_ADDR_I == 8'h9D;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ========================================================================
  // Properties
  property p_hit;
    SFR_HIT_O == (SFR_ADDR_I inside {8'h9A, 8'h9B, 8'h9D});
  endproperty
  a_hit: assert property (p_hit) else $error("hit wrong");
  property p_on;
    wa |=> CMP_A_ON_O == $past(SFR_WDATA_I[7]);
  endproperty
  a_on: assert property (p_on) else $error("on bit wrong");
  property p_hys;
    wa |=> {CMP_A_POS_HYST_O, CMP_A_NEG_HYST_O} == $past(SFR_WDATA_I[3:0]);
  endproperty
  a_hys: assert property (p_hys) else $error("hysteresis wrong");
  property p_spd;
    wm |=> CMP_A_SPEED_SEL_O == $past(SFR_WDATA_I[1:0]);
  endproperty
  a_spd: assert property (p_spd) else $error("speed wrong");
  property p_mdrd;
    rm |=> (SFR_RDATA_O & 8'hCC) == 8'h80;
  endproperty
  a_mdrd: assert property (p_mdrd) else $error("mode fixed bits");
  property p_irq;
    CMP_A_IRQ_O |-> CMP_A_SRC_EN_I && GLOBAL_IRQ_EN_I;
  endproperty
  a_irq: assert property (p_irq) else $error("irq ungated");
  // Four idle cycles cover the gate and synchroniser flops.
  property p_off;
    !CMP_A_ON_O [*4] ##0 ra |=> !SFR_RDATA_O[6];
  endproperty
  a_off: assert property (p_off) else $error("off result set");
  property p_rst;
    $rose(RST_N_I) |-> CMP_A_SPEED_SEL_O == 2'h2 && !CMP_A_ON_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  c_irq: cover property (CMP_A_IRQ_O);
  c_rise: cover property (ra ##1 SFR_RDATA_O[5]);
  c_fall: cover property (ra ##1 SFR_RDATA_O[4]);
endmodule

bind dccr_regs dccr_regs_properties u_chk (.*);

// *** verif/dccr_regs_tb.sv ***
// Self-checking bench for the comparator register bank.
module dccr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, wr, rd, raw_a, raw_b, src, glb;
  logic [7:0] addr, wdata;
  wire  [7:0] rdata;
  wire        on_a, irq;
  wire  [1:0] ph, nh, spd;
  int         num_errors, checked, i;
  dccr_regs uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata), .SFR_HIT_O(), .CMP_A_RAW_I(raw_a),
    .CMP_B_RAW_I(raw_b), .CMP_A_ON_O(on_a), .CMP_B_ON_O(),
    .CMP_A_POS_HYST_O(ph), .CMP_A_NEG_HYST_O(nh), .CMP_B_POS_HYST_O(),
    .CMP_B_NEG_HYST_O(), .CMP_A_SPEED_SEL_O(spd), .CMP_A_SRC_EN_I(src),
    .GLOBAL_IRQ_EN_I(glb), .CMP_A_IRQ_O(irq));
  // ========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // The raw input needs three edges to reach the flags; four leave margin.
  task automatic set_raw(input logic a, b);
    @(posedge clk);
    raw_a <= a;
    raw_b <= b;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ========================================================================
  // Stimulus
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial
  begin
    {rst_n, wr, rd, raw_a, raw_b, glb} = '0;
    src = 1'b1;
    addr = '0;
    wdata = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h9A, 8'h00);
    rd_reg(8'h9B, 8'h00);
    rd_reg(8'h9D, 8'h82);
    rd_reg(8'h9C, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
      wr_reg(8'h9B, {4'h8, i[1:0], ~i[1:0]});
      chk({ph, nh}, {4'h0, i[1:0], ~i[1:0]});
      wr_reg(8'h9D, 8'hCC | i[7:0]);
      rd_reg(8'h9D, 8'h80 | i[7:0]);
    end
    $display("field test done");
    wr_reg(8'h9D, 8'hB0);
    set_raw(1'b1, 1'b0);
    chk(irq, 8'h00);
    rd_reg(8'h9B, 8'hEC);
    @(posedge clk) glb <= 1'b1;
    #1 chk(irq, 8'h01);
    wr_reg(8'h9B, 8'hDC);
    rd_reg(8'h9B, 8'hCC);
    chk(irq, 8'h00);
    set_raw(1'b0, 1'b0);
    rd_reg(8'h9B, 8'h9C);
    chk(irq, 8'h01);
    wr_reg(8'h9D, 8'hA0);
    chk(irq, 8'h00);
    wr_reg(8'h9B, 8'h8C);
    rd_reg(8'h9B, 8'h8C);
    @(posedge clk) raw_a <= 1'b1;
    @(posedge clk);
    wr_reg(8'h9B, 8'h8C);
    rd_reg(8'h9B, 8'hEC);
    $display("edge test done");
    wr_reg(8'h9B, 8'h00);
    chk(on_a, 8'h00);
    wr_reg(8'h9A, 8'h85);
    set_raw(1'b1, 1'b1);
    rd_reg(8'h9B, 8'h10);
    rd_reg(8'h9A, 8'hE5);
    $display("channel test done");
    complete_run;
  end
endmodule
